// ==== inc/rss_pkg.sv ====
// constants, types and register map of the sgi status and error register bank
// Operation
// - status bit 31 reads the synchronised core-active input level
// - bit 31 may be meaningless while core sleep or subunits idle is set
// - status bit 30 reads the wakeup request level toward power control
// - status bit 4 reads 0 for secure, 1 for non-secure access
// - bit 2: secure g1 enable on secure reads in two-state mode, else zero
// - bit 1 two-state: g1ns enable on secure reads, non-secure only with routing
// - bit 1 single-state: the group 1 enable copy
// - bit 0: g0 enable, or g1ns for two-state non-secure reads without routing, zero with routing
// - enable copies follow upstream packets and may go stale across power-down
// - status register readable by secure and non-secure accesses alike
// - error clear and default registers are secure only
// - corruption of an sgi's stored data sets its error flag
// - error flags read back in bits 15:0 and block delivery
// - writing one clears an error flag, writing zero leaves it
// - defaults replace an sgi's settings after a double-bit error
// - four default bits per sgi: permit, group, modifier, reserved
// - without sgi ecc the default register reads zero, ignores writes
// - each 32-bit half of the default register is written alone
package rss_pkg;
  localparam int unsigned NUM_SGI = 16;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] OFF_MISC = 16'hC000;
  localparam logic [15:0] OFF_ERRCLR = 16'hC008;
  localparam logic [15:0] OFF_DFLT_LO = 16'hC010;
  localparam logic [15:0] OFF_DFLT_HI = 16'hC014;
  localparam logic [15:0] OFF_CFG = 16'hC020;
  localparam logic [15:0] OFF_IRQ_STAT = 16'hC030;
  localparam logic [15:0] OFF_IRQ_CLR = 16'hC034;
  localparam logic [15:0] OFF_IRQ_EN = 16'hC038;
  localparam int unsigned MISC_CPU_ACT = 31;
  localparam int unsigned MISC_WAKE = 30;
  localparam int unsigned MISC_KIND = 4;
  localparam int unsigned MISC_G1S = 2;
  localparam int unsigned MISC_G1NS = 1;
  localparam int unsigned MISC_G0 = 0;
  localparam int unsigned CFG_SINGLE = 0;
  localparam int unsigned CFG_ARE_NS = 1;
  localparam int unsigned IRQ_ERR = 0;
  localparam int unsigned IRQ_DED = 1;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned NIB_W = 4;
  localparam logic [31:0] DFLT_MASK = 32'h7777_7777;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } rss_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic nonsec;
  } rss_aphase_t;

  typedef struct packed {
    logic g0;
    logic g1ns;
    logic g1s;
  } rss_grp_en_t;

  typedef struct packed {
    logic valid;
    rss_grp_en_t en;
  } rss_en_pkt_t;

  typedef struct packed {
    logic default_group_modifier;
    logic default_group_select;
    logic default_nonsecure_permit;
  } rss_sgi_cfg_t;
endpackage

// ==== hdl/rss_regs.sv ====
// sgi status, error clear and default register bank on ahb-lite
module rss_regs #(
  parameter bit SGI_ECC_EN = 1'b1
) (
  input logic clk_sys,
  input logic rstn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic hnonsec,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic cpuActive,
  input logic wakeRequest,
  input logic core_sleep_flag,
  input logic subunits_idle_flag,
  input rss_pkg::rss_en_pkt_t enPkt,
  input logic [15:0] sgiErrDetect,
  input logic [15:0] sgiDedErr,
  input rss_pkg::rss_sgi_cfg_t [15:0] sgiCfgStored,
  output rss_pkg::rss_sgi_cfg_t [15:0] sgiCfgEff,
  output logic [15:0] sgiInError,
  output logic irq
);
  import rss_pkg::*;

  logic cpuActMeta;
  logic cpuActSync;
  rss_phase_t phase;
  rss_aphase_t cap;
  logic take;
  logic wrEn;
  logic wrSec;
  logic rdSec;
  rss_grp_en_t grpEn;
  logic singleState;
  logic areNs;
  logic [15:0] errFlags;
  logic [15:0] dedMark;
  logic [15:0] errClr;
  logic [15:0] dedEvt;
  logic [63:0] sgiDflt;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqEn;
  logic [IRQ_W-1:0] irqClr;
  logic [IRQ_W-1:0] irqEvt;
  logic [31:0] rdMux;
  logic miscG1s;
  logic miscG1ns;
  logic miscG0;
  rss_sgi_cfg_t [15:0] next_cfgEff;

  // pin from the core's domain, two flops before use
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cpuActMeta <= 1'b0;
      cpuActSync <= 1'b0;
    end else begin
      cpuActMeta <= cpuActive;
      cpuActSync <= cpuActMeta;
    end
  end

  // bus front end
  assign take = hsel & htrans[1] & hready;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      phase <= PH_IDLE;
      cap <= '0;
    end else if (take) begin
      phase <= hwrite ? PH_WRITE : PH_READ;
      cap.addr <= haddr[ADDR_W-1:0];
      cap.nonsec <= hnonsec;
    end else begin
      phase <= PH_IDLE;
    end
  end

  // one wait state on reads so writes just committed are seen
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hrdata <= WORD_ZERO;
    end else if (phase == PH_READ) begin
      hrdata <= rdMux;
    end
  end

  assign wrEn = (phase == PH_WRITE);
  assign wrSec = wrEn & ~cap.nonsec;
  assign rdSec = ~cap.nonsec;

  // mirrored interface enables
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      grpEn <= '0;
    end else if (enPkt.valid) begin
      grpEn <= enPkt.en;
    end
  end

  // security configuration, secure writes only
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      singleState <= 1'b0;
      areNs <= 1'b0;
    end else if (wrSec && cap.addr == OFF_CFG) begin
      singleState <= hwdata[CFG_SINGLE];
      areNs <= hwdata[CFG_ARE_NS];
    end
  end

  // status enable bits by access security
  always_comb begin
    miscG1s = ~singleState & rdSec & grpEn.g1s;
    if (singleState) begin
      miscG1ns = grpEn.g1ns;
    end else if (rdSec) begin
      miscG1ns = grpEn.g1ns;
    end else begin
      miscG1ns = areNs & grpEn.g1ns;
    end
    if (singleState || rdSec) begin
      miscG0 = grpEn.g0;
    end else begin
      miscG0 = ~areNs & grpEn.g1ns;
    end
  end

  // sgi error flags, set wins over clear
  assign errClr = (wrSec && cap.addr == OFF_ERRCLR) ? hwdata[15:0] : 16'h0000;
  assign dedEvt = SGI_ECC_EN ? sgiDedErr : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      errFlags <= 16'h0000;
    end else begin
      errFlags <= (errFlags & ~errClr) | sgiErrDetect | dedEvt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dedMark <= 16'h0000;
    end else begin
      dedMark <= (dedMark & ~errClr) | dedEvt;
    end
  end

  // flags double as the delivery block toward the core
  assign sgiInError = errFlags;

  // default settings, halves written separately
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sgiDflt <= 64'h0000_0000_0000_0000;
    end else if (SGI_ECC_EN && wrSec) begin
      if (cap.addr == OFF_DFLT_LO) begin
        sgiDflt[31:0] <= hwdata & DFLT_MASK;
      end else if (cap.addr == OFF_DFLT_HI) begin
        sgiDflt[63:32] <= hwdata & DFLT_MASK;
      end
    end
  end

  // substitution lasts until software clears the error
  always_comb begin
    for (int n = 0; n < NUM_SGI; n++) begin
      if (dedMark[n]) begin
        next_cfgEff[n] = rss_sgi_cfg_t'(sgiDflt[NIB_W*n +: 3]);
      end else begin
        next_cfgEff[n] = sgiCfgStored[n];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sgiCfgEff <= '0;
    end else begin
      sgiCfgEff <= next_cfgEff;
    end
  end

  // interrupt status, clear and enable
  assign irqEvt[IRQ_ERR] = |(sgiErrDetect | dedEvt);
  assign irqEvt[IRQ_DED] = |dedEvt;
  assign irqClr = (wrEn && cap.addr == OFF_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqStat <= '0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqEvt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqEn <= '0;
    end else if (wrEn && cap.addr == OFF_IRQ_EN) begin
      irqEn <= hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqEn);
    end
  end

  // read mux; unmapped and refused words read zero
  always_comb begin
    rdMux = WORD_ZERO;
    case (cap.addr)
      OFF_MISC: begin
        // no gating on sleep: bit 31 is simply not trusted then
        rdMux[MISC_CPU_ACT] = cpuActSync;
        rdMux[MISC_WAKE] = wakeRequest;
        rdMux[MISC_KIND] = cap.nonsec;
        rdMux[MISC_G1S] = miscG1s;
        rdMux[MISC_G1NS] = miscG1ns;
        rdMux[MISC_G0] = miscG0;
      end
      OFF_ERRCLR: begin
        if (rdSec) begin
          rdMux[15:0] = errFlags;
        end
      end
      OFF_DFLT_LO: begin
        if (rdSec && SGI_ECC_EN) begin
          rdMux = sgiDflt[31:0];
        end
      end
      OFF_DFLT_HI: begin
        if (rdSec && SGI_ECC_EN) begin
          rdMux = sgiDflt[63:32];
        end
      end
      OFF_CFG: begin
        if (rdSec) begin
          rdMux[CFG_SINGLE] = singleState;
          rdMux[CFG_ARE_NS] = areNs;
        end
      end
      OFF_IRQ_STAT: begin
        rdMux[IRQ_W-1:0] = irqStat;
      end
      OFF_IRQ_EN: begin
        rdMux[IRQ_W-1:0] = irqEn;
      end
      default: begin
        rdMux = WORD_ZERO;
      end
    endcase
  end

  logic unusedIn;
  assign unusedIn = ^{haddr[31:ADDR_W], hsize, core_sleep_flag, subunits_idle_flag};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic rdMisc;
  assign rdMisc = (phase == PH_READ) && (cap.addr == OFF_MISC);

  AST_CPU_ACTIVE: assert property (rdMisc |=> hrdata[MISC_CPU_ACT] == $past(cpuActSync))
    else $error("status bit 31 does not follow core active");
  AST_WAKE: assert property (rdMisc |=> hrdata[MISC_WAKE] == $past(wakeRequest))
    else $error("status bit 30 does not follow wakeup");
  AST_ACCESS_KIND: assert property (rdMisc |=> hrdata[MISC_KIND] == $past(cap.nonsec))
    else $error("status bit 4 wrong access kind");
  AST_G1S_HIDDEN: assert property (rdMisc && (cap.nonsec || singleState) |=> !hrdata[MISC_G1S])
    else $error("secure group 1 enable leaked");
  AST_G0_NS_NOROUTE: assert property (rdMisc && cap.nonsec && !singleState && !areNs
      |=> hrdata[MISC_G0] == $past(grpEn.g1ns) && !hrdata[MISC_G1NS])
    else $error("bits 1 and 0 wrong for non-secure read without routing");
  AST_RSVD_ZERO: assert property (rdMisc |=> hrdata[29:5] == 25'h0 && !hrdata[3])
    else $error("reserved status bits not zero");
  AST_SEC_ONLY: assert property ((phase == PH_READ) && cap.nonsec
      && (cap.addr == OFF_ERRCLR || cap.addr == OFF_DFLT_LO) |=> hrdata == 32'h0)
    else $error("secure only register visible to non-secure read");
  AST_ERR_SET: assert property (|sgiErrDetect
      |=> (errFlags & $past(sgiErrDetect)) == $past(sgiErrDetect))
    else $error("error flag not set on detect");
  AST_W1C: assert property (wrSec && cap.addr == OFF_ERRCLR && sgiErrDetect == 16'h0 && dedEvt == 16'h0
      |=> errFlags == ($past(errFlags) & ~$past(hwdata[15:0])))
    else $error("write one clear misbehaved");
  AST_DFLT_SUBST: assert property (dedEvt[3] && SGI_ECC_EN
      |=> ##1 sgiCfgEff[3] == rss_sgi_cfg_t'($past(sgiDflt[14:12])))
    else $error("defaults not substituted after double-bit error");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  COV_MISC_READ_NS: cover property (rdMisc && cap.nonsec);
  COV_ERR_CLEAR: cover property (wrSec && cap.addr == OFF_ERRCLR && errFlags != 16'h0);
  COV_DED_SUBST: cover property (dedEvt != 16'h0 ##2 dedMark != 16'h0);
  COV_IRQ_RISE: cover property (!irq ##1 irq);
endmodule

// ==== test/rss_core_model.sv ====
// core interface and power controller model driving the status inputs
module rss_core_model (
  input wire logic clk_sys,
  output rss_pkg::rss_en_pkt_t enPkt,
  output logic cpuActive,
  output logic wakeRequest,
  output logic core_sleep_flag,
  output logic subunits_idle_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  import rss_pkg::*;
  // sleep flags stay low, otherwise bit 31 could not be judged
  initial begin
    enPkt = '0;
    cpuActive = 1'b0;
    wakeRequest = 1'b0;
    core_sleep_flag = 1'b0;
    subunits_idle_flag = 1'b0;
  end
  task automatic sendEn(input rss_grp_en_t en);
    @(posedge clk_sys);
    enPkt <= {1'b1, en};
    @(posedge clk_sys);
    enPkt <= '0;
  endtask
  task automatic setPower(input logic act, input logic wake);
    @(posedge clk_sys);
    cpuActive <= act;
    wakeRequest <= wake;
  endtask
endmodule

// ==== test/rss_regs_tb.sv ====
// self-checking bench for the sgi status, error and default registers
module rss_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rss_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic hnonsec = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, irq, cpuActive, wakeRequest, sleepFlag, idleFlag;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] sgiErrDetect = '0;
  logic [15:0] sgiDedErr = '0;
  logic [15:0] sgiInError;
  rss_sgi_cfg_t [15:0] sgiCfgStored = {16{3'b100}};
  rss_sgi_cfg_t [15:0] sgiCfgEff;
  rss_en_pkt_t enPkt;
  int errTotal = 0;
  int cmpCount = 0;

  always #10 clk_sys = ~clk_sys;

  rss_core_model i_rss_core_model (.clk_sys(clk_sys), .enPkt(enPkt), .cpuActive(cpuActive),
    .wakeRequest(wakeRequest), .core_sleep_flag(sleepFlag), .subunits_idle_flag(idleFlag));
  rss_regs i_rss_regs (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hnonsec(hnonsec), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpuActive(cpuActive),
    .wakeRequest(wakeRequest), .core_sleep_flag(sleepFlag), .subunits_idle_flag(idleFlag),
    .enPkt(enPkt), .sgiErrDetect(sgiErrDetect), .sgiDedErr(sgiDedErr), .sgiCfgStored(sgiCfgStored),
    .sgiCfgEff(sgiCfgEff), .sgiInError(sgiInError), .irq(irq));

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // no cycle count assumed, the watchdog catches a slave that never answers
  task automatic waitRdy();
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic busXfer(input logic [15:0] a, input logic wr, input logic ns, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hnonsec <= ns;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [15:0] a, input logic ns, input logic [31:0] d);
    busXfer(a, 1'b1, ns, d);
  endtask
  task automatic rdChk(input string what, input logic [15:0] a, input logic ns, input logic [31:0] exp);
    busXfer(a, 1'b0, ns, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic pulse(input logic [15:0] e, input logic [15:0] d);
    sgiErrDetect <= e;
    sgiDedErr <= d;
    @(posedge clk_sys);
    sgiErrDetect <= '0;
    sgiDedErr <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic tReset();
    rdChk("status", OFF_MISC, 1'b0, 32'h0000_0000);
    rdChk("flags", OFF_ERRCLR, 1'b0, 32'h0000_0000);
    rdChk("defaults", OFF_DFLT_LO, 1'b0, 32'h0000_0000);
    rdChk("unmapped", 16'hC004, 1'b0, 32'h0000_0000);
  endtask
  // cpu active passes two sync flops, so allow a few edges
  task automatic tPins();
    i_rss_core_model.setPower(1'b1, 1'b1);
    repeat (3) @(posedge clk_sys);
    rdChk("status secure", OFF_MISC, 1'b0, 32'hC000_0000);
    rdChk("status nonsecure", OFF_MISC, 1'b1, 32'hC000_0010);
    i_rss_core_model.setPower(1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    rdChk("status idle core", OFF_MISC, 1'b0, 32'h4000_0000);
    i_rss_core_model.setPower(1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic tEnables();
    rss_grp_en_t en;
    logic [31:0] exp;
    for (int p = 0; p < 2; p++) begin
      en = (p == 0) ? 3'b101 : 3'b010;
      i_rss_core_model.sendEn(en);
      for (int m = 0; m < 4; m++) begin
        wr(OFF_CFG, 1'b0, 32'(m));
        for (int s = 0; s < 2; s++) begin
          exp = {27'h0, s[0], 4'h0};
          if (m[CFG_SINGLE]) exp[2:0] = {1'b0, en.g1ns, en.g0};
          else if (s == 0) exp[2:0] = {en.g1s, en.g1ns, en.g0};
          else exp[2:0] = {1'b0, m[CFG_ARE_NS] & en.g1ns, !m[CFG_ARE_NS] & en.g1ns};
          rdChk("enable copies", OFF_MISC, s[0], exp);
        end
      end
    end
    wr(OFF_CFG, 1'b0, 32'h0);
  endtask
  task automatic tErrors();
    wr(OFF_IRQ_EN, 1'b0, 32'h0);
    pulse(16'hA5A5, 16'h0000);
    check("blocked", {16'h0, sgiInError}, 32'h0000_A5A5);
    check("masked irq", {31'h0, irq}, 32'h0);
    rdChk("irq status", OFF_IRQ_STAT, 1'b1, 32'h1);
    wr(OFF_IRQ_EN, 1'b1, 32'h3);
    repeat (2) @(posedge clk_sys);
    check("irq", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_CLR, 1'b0, 32'h3);
    repeat (2) @(posedge clk_sys);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdChk("flags", OFF_ERRCLR, 1'b0, 32'h0000_A5A5);
    rdChk("flags nonsecure", OFF_ERRCLR, 1'b1, 32'h0);
    wr(OFF_ERRCLR, 1'b1, 32'h0000_FFFF);
    wr(OFF_ERRCLR, 1'b0, 32'hFFFF_0005);
    rdChk("flags cleared", OFF_ERRCLR, 1'b0, 32'h0000_A5A0);
  endtask
  task automatic tDefaults();
    wr(OFF_DFLT_LO, 1'b0, 32'hFFFF_FFFF);
    rdChk("defaults mask", OFF_DFLT_LO, 1'b0, 32'h7777_7777);
    wr(OFF_DFLT_HI, 1'b0, 32'h1234_5678);
    wr(OFF_DFLT_LO, 1'b0, 32'h7654_3210);
    wr(OFF_DFLT_LO, 1'b1, 32'h0);
    rdChk("defaults low", OFF_DFLT_LO, 1'b0, 32'h7654_3210);
    rdChk("defaults high", OFF_DFLT_HI, 1'b0, 32'h1234_5670);
    rdChk("defaults nonsecure", OFF_DFLT_HI, 1'b1, 32'h0);
    pulse(16'h0000, 16'h0208);
    check("ded flags", {16'h0, sgiInError}, 32'h0000_A7A8);
    check("sgi3 defaults", {29'h0, sgiCfgEff[3]}, 32'h3);
    check("sgi9 defaults", {29'h0, sgiCfgEff[9]}, 32'h7);
    check("sgi2 stored", {29'h0, sgiCfgEff[2]}, 32'h4);
    wr(OFF_ERRCLR, 1'b0, 32'h0000_0208);
    // mark clears at the commit edge, the settings flop follows one edge later
    repeat (2) @(posedge clk_sys);
    check("sgi3 restored", {29'h0, sgiCfgEff[3]}, 32'h4);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    tReset();
    tPins();
    tEnables();
    tErrors();
    tDefaults();
    testDone();
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errTotal++;
    testDone();
  end
endmodule
